// file: inc/vdec_pin_regs.svh
// register map, field positions, reset values and timing counts of the
// pin control block; assumes a 32-bit apb data path
`ifndef VDEC_PIN_REGS_SVH
`define VDEC_PIN_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_VBLANK    8'h04
`define OFS_STATUS    8'h08
`define OFS_EVENTS    8'h0C
`define OFS_CPLL      8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_FID_SEL   0
`define CTRL_VS_LO     1
`define CTRL_VS_HI     2
`define CTRL_MPP_LO    3
`define CTRL_MPP_HI    4
`define CTRL_GPO_LVL   5
`define CTRL_RTC       6
`define CTRL_SCLK2X    7
`define CTRL_MUX_LO    8
`define CTRL_MUX_HI    9
`define CTRL_EMBED     10
`define CTRL_W         11
`define CTRL_RST       11'h000

// ----------------------------------------------------------------
// blanking window fields and defaults
// ----------------------------------------------------------------
`define VBL_START_LO   0
`define VBL_END_LO     16
`define VBL_LINE_W     10
`define VBL_START_RST  10'h001
`define VBL_END_RST    10'h014

// ----------------------------------------------------------------
// bus addresses, timing
// ----------------------------------------------------------------
`define BUS_ADDR_HI    8'hBA
`define BUS_ADDR_LO    8'hB8
`define REF_PERIOD_NS  100
`define PIX_HALF_NS    400
`define NOM_HALF_CYC   (`PIX_HALF_NS / `REF_PERIOD_NS)
`define HALF_CNT_W     8
`define RTC_DIV_W      2

`endif

// file: inc/vdec_pin_pkg.sv
// types shared by the pin control block and its surroundings
// assumes nothing beyond a systemverilog compiler
package vdec_pin_pkg;

    // function of the multi purpose pin
    typedef enum logic [1:0] {
        MPP_IRQ,
        MPP_GPO,
        MPP_VBLANK,
        MPP_SYNCLOCK
    } mpp_mode_t;

    // function of the shared vertical sync pin
    typedef enum logic [1:0] {
        VS_VSYNC,
        VS_LINE_PHASE,
        VS_HLOCK,
        VS_RSVD
    } vs_sel_t;

    // timing reported by the decoder core, same clock domain
    typedef struct packed {
        logic       oddField;
        logic       vertLock;
        logic       horzLock;
        logic       lineNonInv;
        logic       activeVideo;
        logic       hsync;
        logic       vsync;
        logic [9:0] lineNum;
    } timing_t;

endpackage : vdec_pin_pkg

// file: src/video_decoder_pin_control_status.sv
// pin level control and status of the video decoder: shared sync pins,
// serial color pll output, multi purpose pin, power and reset, strap
// assumes an apb master on ref_clk and a decoder core on the same clock
//
// What this block does
// - field output high in odd field
// - field pin selects parity or vertical lock
// - genlock shifts one bit per sclk
// - rtc mode shifts at sclk over four
// - multi pin can signal pending interrupts
// - multi pin output follows host written level
// - multi pin marks programmed vertical blank window
// - multi pin input high forces nominal timing
// - power down gives standby, registers kept
// - reset pin honoured only when powered up
// - reset pin restores defaults, restarts processor
// - sclk runs at one or two pixel rate
// - vsync pin gives line phase or hlock
// - strap high 0xBA, low 0xB8 address
// - pixel bus embedded or discrete syncs
// - input mux picks composite or s-video
// - active video flag high during active line
`timescale 1ns/1ns
`include "vdec_pin_regs.svh"

module video_decoder_pin_control_status
    import vdec_pin_pkg::*;
#(
    parameter int CPLL_W = 24
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // decoder core
    input  wire timing_t               timing,
    input  wire logic [7:0]            pixData,
    // pins from outside
    input  wire logic                  pixClk,
    input  wire logic                  power_down_n,
    input  wire logic                  reset_n_in,
    input  wire logic                  bus_address_strap,
    input  wire logic                  mppIn,
    // pins to outside
    output logic                       field_parity_out,
    output logic                       color_lock_serial_out,
    output logic                       vsyncPinOut,
    output logic                       hsyncOut,
    output logic                       active_video_flag,
    output logic                       sclkOut,
    output logic                       mppOut,
    output logic                       mppOe_n,
    output logic [7:0]                 pixel_out_bus,
    output logic                       pixOe_n,
    // core control
    output logic [1:0]                 inputSel,
    output logic                       forceNominal,
    output logic                       standby,
    output logic                       cpuRestart,
    output logic [7:0]                 busAddress
);

    initial begin
        if (CPLL_W < 2 || CPLL_W > 32) $error("CPLL_W must be 2..32");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pixClkS, pdnS, rstnS, strapS, mppS;
    logic       pixClkD;

    // two stages for every pin; only stage [1] is read further on
    always_ff @(posedge ref_clk) begin
        pixClkS <= {pixClkS[0], pixClk};
        pdnS    <= {pdnS[0], power_down_n};
        rstnS   <= {rstnS[0], reset_n_in};
        strapS  <= {strapS[0], bus_address_strap};
        mppS    <= {mppS[0], mppIn};
        pixClkD <= pixClkS[1];
    end

    wire logic pixEdge  = pixClkS[1] ^ pixClkD;
    // reset pin is ignored while powered down
    wire logic softRst  = pdnS[1] & ~rstnS[1];
    wire logic anyRst   = srst | softRst;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [`CTRL_W-1:0]     ctrl;
    logic [`VBL_LINE_W-1:0] vblStart, vblEnd;
    logic [1:0]             events;
    logic [CPLL_W-1:0]      cpllWord;
    logic                   addrTaken;

    wire mpp_mode_t mppMode  = mpp_mode_t'(ctrl[`CTRL_MPP_HI:`CTRL_MPP_LO]);
    wire vs_sel_t   vsSel    = vs_sel_t'(ctrl[`CTRL_VS_HI:`CTRL_VS_LO]);
    wire logic      rtcMode  = ctrl[`CTRL_RTC];
    wire logic      sclk2x   = ctrl[`CTRL_SCLK2X];
    wire logic      embedded = ctrl[`CTRL_EMBED];

    // apb decode
    wire logic setupPh  = psel & ~penable;
    wire logic accessPh = psel & penable & pready;
    wire logic selCtrl  = paddr == `OFS_CTRL;
    wire logic selVbl   = paddr == `OFS_VBLANK;
    wire logic selStat  = paddr == `OFS_STATUS;
    wire logic selEvt   = paddr == `OFS_EVENTS;
    wire logic selCpll  = paddr == `OFS_CPLL;
    wire logic mapped   = selCtrl | selVbl | selStat | selEvt | selCpll;
    wire logic wrEn     = accessPh & pwrite & mapped;

    wire logic [31:0] statWord = {16'h0000, 2'b00, addrTaken,
        standby, timing.oddField, timing.vertLock, timing.horzLock,
        mppS[1], busAddress};
    wire logic [31:0] rdMux =
        selCtrl ? {{(32-`CTRL_W){1'b0}}, ctrl} :
        selVbl  ? {6'h00, vblEnd, 6'h00, vblStart} :
        selStat ? statWord :
        selEvt  ? {30'h0000_0000, events} :
        selCpll ? {{(32-CPLL_W){1'b0}}, cpllWord} : 32'h0000_0000;

    // no wait state; read data and ready come from flops loaded in the setup phase
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            prdata  <= setupPh ? rdMux : 32'h0000_0000;
            pslverr <= setupPh & ~mapped;
        end
    end

    // configuration state; both reset sources restore defaults
    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            ctrl     <= `CTRL_RST;
            vblStart <= `VBL_START_RST;
            vblEnd   <= `VBL_END_RST;
            cpllWord <= '0;
        end else if (wrEn) begin
            if (selCtrl) ctrl <= pwdata[`CTRL_W-1:0];
            if (selVbl) begin
                vblStart <= pwdata[`VBL_START_LO +: `VBL_LINE_W];
                vblEnd   <= pwdata[`VBL_END_LO +: `VBL_LINE_W];
            end
            if (selCpll) cpllWord <= pwdata[CPLL_W-1:0];
        end
    end

    // lock change events: sticky, write one to clear, set beats clear
    logic vLockD, hLockD;
    wire logic [1:0] evtSet = {timing.horzLock ^ hLockD,
                               timing.vertLock ^ vLockD};
    wire logic [1:0] evtClr = (wrEn & selEvt) ? pwdata[1:0] : 2'b00;

    always_ff @(posedge ref_clk) begin
        vLockD <= timing.vertLock;
        hLockD <= timing.horzLock;
        if (anyRst) events <= 2'b00;
        else events <= (events & ~evtClr) | evtSet;
    end

    // ----------------------------------------------------------------
    // startup sequencing and address strap
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_RESET, ST_SAMPLE, ST_RUN, ST_STANDBY}
        state_t;
    state_t state;

    // address caught once after reset ends, before the bus bit drives
    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            state      <= ST_RESET;
            addrTaken  <= 1'b0;
            busAddress <= `BUS_ADDR_LO;
            standby    <= 1'b0;
            cpuRestart <= softRst;
        end else begin
            cpuRestart <= 1'b0;
            unique case (state)
                ST_RESET: state <= ST_SAMPLE;
                ST_SAMPLE: begin
                    busAddress <= strapS[1] ? `BUS_ADDR_HI
                                            : `BUS_ADDR_LO;
                    addrTaken  <= 1'b1;
                    state      <= ST_RUN;
                end
                ST_RUN: begin
                    if (!pdnS[1]) begin
                        standby <= 1'b1;
                        state   <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (pdnS[1]) begin
                        standby <= 1'b0;
                        state   <= ST_RUN;
                    end
                end
            endcase
        end
    end

    wire logic running = (state == ST_RUN);

    // ----------------------------------------------------------------
    // system clock out
    // ----------------------------------------------------------------
    logic [`HALF_CNT_W-1:0] halfCnt, halfPer;
    // sync lock input pins timing to the nominal pixel period
    wire logic nominal = (mppMode == MPP_SYNCLOCK) & mppS[1];
    wire logic nomTick = halfCnt >= `HALF_CNT_W'(`NOM_HALF_CYC - 1);
    wire logic baseTick = nominal ? nomTick : pixEdge;
    wire logic midTick  = sclk2x & (halfCnt == (halfPer >> 1))
                          & (halfCnt != '0);
    wire logic sclkTog  = running & (baseTick | midTick);
    wire logic sclkRise = sclkTog & ~sclkOut;

    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            halfCnt      <= '0;
            halfPer      <= `HALF_CNT_W'(`NOM_HALF_CYC);
            sclkOut      <= 1'b0;
            forceNominal <= 1'b0;
        end else begin
            forceNominal <= nominal;
            if (baseTick) begin
                halfCnt <= '0;
                halfPer <= halfCnt + 1'b1;
            end else if (~&halfCnt) begin
                halfCnt <= halfCnt + 1'b1;
            end
            // standby stops the clock low
            if (!running) sclkOut <= 1'b0;
            else if (sclkTog) sclkOut <= ~sclkOut;
        end
    end

    // ----------------------------------------------------------------
    // serial colour pll word
    // ----------------------------------------------------------------
    logic [`RTC_DIV_W-1:0] rtcDiv;
    logic [CPLL_W-1:0]     shiftReg;
    logic [4:0]            bitCnt;
    // rtc moves a bit on every fourth sclk rising edge
    wire logic shiftStep = sclkRise & (~rtcMode | (&rtcDiv));

    // word reloads after its last bit, msb first
    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            rtcDiv                <= '0;
            shiftReg              <= '0;
            bitCnt                <= '0;
            color_lock_serial_out <= 1'b0;
        end else begin
            if (sclkRise) rtcDiv <= rtcDiv + 1'b1;
            if (shiftStep) begin
                color_lock_serial_out <= (bitCnt == '0)
                    ? cpllWord[CPLL_W-1] : shiftReg[CPLL_W-1];
                if (bitCnt == '0) begin
                    shiftReg <= cpllWord << 1;
                    bitCnt   <= 5'(CPLL_W - 1);
                end else begin
                    shiftReg <= shiftReg << 1;
                    bitCnt   <= bitCnt - 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // shared pins, multi purpose pin and pixel bus
    // ----------------------------------------------------------------
    wire logic inVblank = (timing.lineNum >= vblStart)
                          & (timing.lineNum <= vblEnd);
    wire logic fieldPin = ctrl[`CTRL_FID_SEL] ? timing.vertLock
                                              : timing.oddField;
    wire logic vsPin = (vsSel == VS_LINE_PHASE) ? timing.lineNonInv
                     : (vsSel == VS_HLOCK) ? timing.horzLock
                     : timing.vsync;
    wire logic mppDrive = (mppMode == MPP_IRQ) ? |events
                        : (mppMode == MPP_GPO) ? ctrl[`CTRL_GPO_LVL]
                        : inVblank;
    // mux code 3 is not defined and falls back to input a
    wire logic [1:0] muxCode = ctrl[`CTRL_MUX_HI:`CTRL_MUX_LO];

    // pins quiet in standby and until the strap has been sampled
    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            field_parity_out  <= 1'b0;
            vsyncPinOut       <= 1'b0;
            hsyncOut          <= 1'b0;
            active_video_flag <= 1'b0;
            mppOut            <= 1'b0;
            mppOe_n           <= 1'b1;
            pixel_out_bus     <= 8'h00;
            pixOe_n           <= 1'b1;
            inputSel          <= 2'b00;
        end else begin
            field_parity_out  <= running & fieldPin;
            vsyncPinOut       <= running & vsPin;
            // discrete format carries syncs on their own pins
            hsyncOut          <= running & ~embedded & timing.hsync;
            active_video_flag <= running & timing.activeVideo;
            mppOut            <= running & mppDrive;
            mppOe_n           <= ~running | (mppMode == MPP_SYNCLOCK);
            pixel_out_bus     <= running ? pixData : 8'h00;
            pixOe_n           <= ~running;
            inputSel          <= (muxCode == 2'b11) ? 2'b00 : muxCode;
        end
    end

endmodule : video_decoder_pin_control_status

// file: sim/vdec_pin_properties.sv
// checker of the pin control block: shared pins, multi pin, power, reset
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/1ns
`include "vdec_pin_regs.svh"

module vdec_pin_properties
    import vdec_pin_pkg::*;
(
    // clock, reset, apb
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // core and pins
    input wire timing_t     timing,
    input wire logic        mppIn,
    input wire logic        power_down_n,
    input wire logic        reset_n_in,
    input wire logic        field_parity_out,
    input wire logic        vsyncPinOut,
    input wire logic        active_video_flag,
    input wire logic        mppOut,
    input wire logic        mppOe_n,
    input wire logic        hsyncOut,
    input wire logic [7:0]  pixData,
    input wire logic [7:0]  pixel_out_bus,
    input wire logic        pixOe_n,
    input wire logic        forceNominal,
    input wire logic        standby,
    input wire logic        cpuRestart,
    input wire logic [7:0]  busAddress
);
    // ----------------------------------------------------------------
    // shadow of the host configuration
    // ----------------------------------------------------------------
    logic [10:0] ctrl;
    logic [31:0] vbl;
    logic [2:0]  quiet;
    wire         wrEn  = psel && penable && pready && pwrite;
    wire         ok    = quiet == 3'h4;
    wire [1:0]   mode  = ctrl[4:3];
    wire [9:0]   line  = timing.lineNum;
    wire         inWin = line >= vbl[9:0] && line <= vbl[25:16];
    wire         vsExp = ctrl[2:1] == 2'h1 ? timing.lineNonInv :
                         ctrl[2:1] == 2'h2 ? timing.horzLock : timing.vsync;

    // registers follow apb writes and fall back on any reset
    always_ff @(posedge ref_clk) begin
        if (srst || cpuRestart) begin
            ctrl <= `CTRL_RST;
            vbl  <= 32'h0014_0001;
        end else if (wrEn && paddr == `OFS_CTRL) begin
            ctrl <= pwdata[10:0];
        end else if (wrEn && paddr == `OFS_VBLANK) begin
            vbl <= pwdata;
        end
    end

    // pins are only judged once the block has run undisturbed a while
    always_ff @(posedge ref_clk) begin
        if (srst || standby || cpuRestart || !power_down_n || !reset_n_in)
            quiet <= 3'h0;
        else if (!ok)
            quiet <= quiet + 3'h1;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence syncHeld; (ok && mode == 2'h3 && mppIn)[*5]; endsequence
    sequence downHeld; (!power_down_n)[*5]; endsequence
    sequence softHeld; (power_down_n && !reset_n_in)[*5]; endsequence

    a_field_parity: assert property (ok && !ctrl[0] |=>
        field_parity_out == $past(timing.oddField)) else $error("field odd");
    a_field_lock: assert property (ok && ctrl[0] |=>
        field_parity_out == $past(timing.vertLock)) else $error("field lock");
    a_vsync_select: assert property (ok |=>
        vsyncPinOut == $past(vsExp)) else $error("vsync pin function");
    a_gpo_level: assert property (ok && mode == 2'h1 |=>
        mppOut == $past(ctrl[5]) && !mppOe_n) else $error("gpo level");
    a_vblank_win: assert property (ok && mode == 2'h2 |=>
        mppOut == $past(inWin) && !mppOe_n) else $error("blank window");
    a_sync_force: assert property (syncHeld |->
        forceNominal && mppOe_n) else $error("nominal not forced");
    a_standby_pd: assert property (downHeld |-> standby)
        else $error("no standby");
    a_reset_gated: assert property (downHeld |-> !cpuRestart)
        else $error("reset taken in power down");
    a_restart_on: assert property (softHeld |-> cpuRestart)
        else $error("no restart");
    a_addr_hold: assert property (ok && $past(ok) |->
        $stable(busAddress)) else $error("address moved");
    a_active_flag: assert property (ok |=>
        active_video_flag == $past(timing.activeVideo)) else $error("active_video_flag");
    a_pixel_bus: assert property (ok |=>
        pixel_out_bus == $past(pixData) && !pixOe_n) else $error("pixel bus");
    a_hsync_disc: assert property (ok && !ctrl[10] |=>
        hsyncOut == $past(timing.hsync)) else $error("discrete hsync");
endmodule : vdec_pin_properties

bind video_decoder_pin_control_status vdec_pin_properties chk_u (.*);

// file: sim/vdec_core_model.sv
// far side model: decoder core timing and the free running pixel clock
// assumes ref_clk from the bench; each line lasts sixteen cycles
`timescale 1ns/1ns

module vdec_core_model
    import vdec_pin_pkg::*;
(
    // clock and reset
    input wire logic   ref_clk,
    input wire logic   srst,
    // toward the block
    output timing_t    timing,
    output logic [7:0] pixData,
    output logic       pixClk
);
    logic [15:0] cnt;

    // pixel clock pin, 800 ns period, phase unrelated to ref_clk
    initial begin
        pixClk = 1'b0;
        #137;
        forever #400 pixClk = ~pixClk;
    end

    // short lines and fields so every timing field moves often
    always_ff @(posedge ref_clk) begin
        if (srst) cnt <= 16'h0000;
        else cnt <= cnt + 16'h0001;
    end
    assign timing.lineNum     = {4'h0, cnt[9:4]};
    assign timing.oddField    = cnt[10];
    assign timing.vertLock    = cnt[11];
    assign timing.horzLock    = cnt[8];
    assign timing.lineNonInv  = cnt[4];
    assign timing.activeVideo = cnt[3:0] > 4'h3;
    assign timing.hsync       = cnt[3:0] == 4'h0;
    assign timing.vsync       = cnt[9:4] < 6'h3;
    assign pixData            = cnt[7:0];
endmodule : vdec_core_model

// file: sim/tb_top.sv
// self checking bench of the pin control block over apb and its pins
// assumes the core model beside the block and the bound checker
`timescale 1ns/1ns
`include "vdec_pin_regs.svh"

module tb_top
    import vdec_pin_pkg::*;
;
    logic        ref_clk, srst, psel, penable, pwrite, err;
    logic [7:0]  paddr, pixData, pixel_out_bus, busAddress;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pixClk, power_down_n, reset_n_in;
    logic        bus_address_strap, mppIn, field_parity_out, hsyncOut;
    logic        color_lock_serial_out, vsyncPinOut, active_video_flag;
    logic        sclkOut, mppOut, mppOe_n, pixOe_n, forceNominal;
    logic        standby, cpuRestart;
    logic [1:0]  inputSel;
    timing_t     timing;
    int          errorCnt, nCompared, k;

    video_decoder_pin_control_status #(.CPLL_W(24)) dut_u (.*);
    vdec_core_model model_u (.*);

    // single reference clock, 100 ns
    always #50 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [31:0] exp, got);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) errorCnt++;
    endtask : apb

    // counts sclk rises that fall inside one high bit of the serial word
    task automatic serial(input logic [31:0] c, input int exp);
        int i;
        logic p;
        apb(1'b1, `OFS_CTRL, c);
        apb(1'b1, `OFS_CPLL, 32'h0000_0001);
        i = 0;
        k = 0;
        while (color_lock_serial_out !== 1'b1 && i < 3000) begin
            @(posedge ref_clk);
            i++;
        end
        p = sclkOut;
        while (color_lock_serial_out === 1'b1 && i < 3000) begin
            @(posedge ref_clk);
            i++;
            if (sclkOut && !p) k++;
            p = sclkOut;
        end
        chk("serial rises per bit", exp, k);
    endtask : serial

    task automatic rises(input logic [31:0] c, input int exp);
        logic p;
        apb(1'b1, `OFS_CTRL, c);
        cyc(20);
        k = 0;
        p = sclkOut;
        repeat (64) begin
            @(posedge ref_clk);
            if (sclkOut && !p) k++;
            p = sclkOut;
        end
        chk("sclk rises", exp, k);
    endtask : rises

    task automatic testRegs;
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0000_0000, rd);
        apb(1'b0, `OFS_VBLANK, 32'h0);
        chk("vblank reset", 32'h0014_0001, rd);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk("unmapped error", 32'h1, err);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("address high", 32'hBA, rd[7:0]);
    endtask : testRegs

    task automatic testMux;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `OFS_CTRL, 32'h0000_0400 | (m << 8));
            cyc(3);
            chk("input select", m == 3 ? 0 : m, inputSel);
            chk("embedded hsync", 32'h0, hsyncOut);
            chk("pixel bus enable", 32'h0, pixOe_n);
        end
    endtask : testMux

    // every vsync pin function, field function alternating parity and lock, blank window on
    task automatic testPins;
        apb(1'b1, `OFS_VBLANK, 32'h0008_0004);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `OFS_CTRL, 32'h0000_0010 | (s << 1) | (s & 1));
            cyc(1100);
        end
    endtask : testPins

    task automatic testMpp;
        apb(1'b1, `OFS_CTRL, 32'h0000_0028);
        cyc(3);
        chk("gpo pin", 32'h1, {mppOe_n, mppOut});
        apb(1'b1, `OFS_CTRL, 32'h0000_0000);
        k = 0;
        while (timing.lineNum[3:0] !== 4'h1 && k < 300) begin
            @(posedge ref_clk);
            k++;
        end
        apb(1'b1, `OFS_EVENTS, 32'h0000_0003);
        cyc(3);
        chk("irq cleared", 32'h0, mppOut);
        cyc(600);
        chk("irq pending", 32'h1, mppOut);
        apb(1'b1, `OFS_CTRL, 32'h0000_0018);
        mppIn <= 1'b1;
        cyc(6);
        chk("nominal forced", 32'h3, {forceNominal, mppOe_n});
        mppIn <= 1'b0;
        cyc(6);
        chk("nominal free", 32'h1, {forceNominal, mppOe_n});
    endtask : testMpp

    task automatic testPower;
        apb(1'b1, `OFS_CTRL, 32'h0000_0123);
        power_down_n <= 1'b0;
        cyc(6);
        chk("standby", 32'h1, standby);
        reset_n_in <= 1'b0;
        cyc(6);
        chk("restart gated", 32'h0, cpuRestart);
        reset_n_in <= 1'b1;
        cyc(2);
        power_down_n <= 1'b1;
        cyc(8);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl kept", 32'h0000_0123, rd);
        reset_n_in <= 1'b0;
        cyc(6);
        chk("restart", 32'h1, cpuRestart);
        reset_n_in <= 1'b1;
        cyc(8);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl default", 32'h0, rd);
    endtask : testPower

    task automatic testStrap;
        bus_address_strap <= 1'b0;
        cyc(3);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        cyc(6);
        bus_address_strap <= 1'b1;
        cyc(6);
        chk("address low", 32'hB8, busAddress);
    endtask : testStrap

    task automatic reportAndStop;
        if (errorCnt == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : reportAndStop

    initial begin
        {ref_clk, psel, penable, pwrite, mppIn} = 5'h0;
        {srst, power_down_n, reset_n_in, bus_address_strap} = 4'hF;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errorCnt = 0;
        nCompared = 0;
        cyc(2);
        srst <= 1'b0;
        testRegs;
        testMux;
        testPins;
        testMpp;
        serial(32'h0000_0000, 1);
        serial(32'h0000_0040, 4);
        rises(32'h0000_0080, 16);
        rises(32'h0000_0000, 8);
        testPower;
        testStrap;
        reportAndStop;
    end

    // watchdog well beyond the expected run of some seven thousand cycles
    initial begin
        #3_000_000;
        errorCnt++;
        reportAndStop;
    end
endmodule : tb_top
